// [verilog/e3rxpo_port.sv]
`timescale 1ns/1ps
// Function
// - serial payload output driven only in serial mode, taken from the quad strap at each frame start
// - four-bit payload outputs driven only in quad mode, taken from the quad strap at each frame start
// - serial mode presents each bit, changed on rising payload clock
// - serial mode payload clock runs continuously at the line rate
// - quad mode clock derived from line clock, 1060 pulses per frame
// - quad mode nibble outputs change on falling payload clock edge
// - serial mode overhead flag high for each overhead bit period
// - quad mode overhead flag held low
// - serial mode frame start high one bit period on first bit
// - quad mode frame start high one nibble period on first nibble
// - quad mode payload clock high about a quarter of each nibble
module e3rxpo_port
   import e3rxpo_pkg::*;
(
   input  wire logic                        i_clock,                      // 100 MHz system clock
   input  wire logic                        i_resetn,                     // async reset, active low
   input  wire logic                        i_recovered_line_clock,       // line clock pin, sampled
   input  wire logic                        i_quad_mode_select_strap,     // high selects nibble mode
   input  wire logic                        i_core_valid,                 // core offers one frame bit
   output logic                             o_core_ready,                 // fifo has room
   input  wire logic                        i_core_bit,                   // frame bit value
   input  wire logic                        i_core_overhead,              // bit is overhead
   input  wire logic                        i_core_sof,                   // bit is first of frame
   output logic                             o_rx_payload_serial_out,      // serial payload bit
   output logic                             o_rx_payload_serial_out_oe,   // serial pin driven
   output logic [e3rxpo_pkg::QUAD_WIDTH-1:0] o_rx_payload_quad_out,       // nibble payload
   output logic                             o_rx_payload_quad_out_oe,     // nibble pins driven
   output logic                             o_rx_payload_clock_out,       // payload clock
   output logic                             o_rx_overhead_bit_flag,       // current bit is overhead
   output logic                             o_rx_frame_start_pulse        // first bit/nibble of frame
);
   import e3rxpo_pkg::*;

   typedef struct packed {
      logic                        line_s1;
      logic                        line_s2;
      logic                        line_prev;
      logic                        strap_s1;
      logic                        strap_s2;
      e3rxpo_mode_t                mode;
      logic                        clk;
      logic                        ser_bit;
      logic                        ohead;
      logic                        frame;
      logic [QUAD_WIDTH-1:0]       quad;
      logic [QUAD_WIDTH-2:0]       shreg;
      logic [QUAD_CNT_WIDTH-1:0]   cnt;
      logic                        sof_pend;
   } e3rxpo_state_t;

   e3rxpo_state_t           st_ff;
   e3rxpo_state_t           nxt_st;
   logic                    line_rise;
   logic                    fifo_valid;
   logic                    pop;
   logic [FIFO_WIDTH-1:0]   fifo_data;
   logic                    pop_bit;
   logic                    pop_oh;
   logic                    pop_sof;
   e3rxpo_mode_t            strap_mode;
   e3rxpo_mode_t            mode_now;

   e3rxpo_fifo #(
      .WIDTH (FIFO_WIDTH),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .i_clock    (i_clock),
      .i_resetn   (i_resetn),
      .i_wr_valid (i_core_valid),
      .o_wr_ready (o_core_ready),
      .i_wr_data  ({i_core_sof, i_core_overhead, i_core_bit}),
      .o_rd_valid (fifo_valid),
      .i_rd_ready (line_rise),
      .o_rd_data  (fifo_data)
   );

   // one frame bit leaves the fifo per line clock rising edge
   assign line_rise  = st_ff.line_s2 & ~st_ff.line_prev;
   assign pop        = line_rise & fifo_valid;
   assign pop_bit    = fifo_data[FLD_DATA_POS];
   assign pop_oh     = fifo_data[FLD_OHEAD_POS];
   assign pop_sof    = pop & fifo_data[FLD_SOF_POS];
   assign strap_mode = st_ff.strap_s2 ? E3RXPO_QUAD : E3RXPO_SERIAL;
   // mode only moves on a frame boundary so a strap glitch cannot split a nibble
   assign mode_now   = pop_sof ? strap_mode : st_ff.mode;

   always_comb begin
      nxt_st           = st_ff;
      nxt_st.line_s1   = i_recovered_line_clock;
      nxt_st.line_s2   = st_ff.line_s1;
      nxt_st.line_prev = st_ff.line_s2;
      nxt_st.strap_s1  = i_quad_mode_select_strap;
      nxt_st.strap_s2  = st_ff.strap_s1;
      nxt_st.mode      = mode_now;
      unique case (mode_now)
         E3RXPO_SERIAL: begin
            // the delayed line clock goes out as is, aligned with the bit update
            nxt_st.clk      = st_ff.line_s2;
            nxt_st.quad     = '0;
            nxt_st.cnt      = '0;
            nxt_st.sof_pend = 1'b0;
            if (line_rise) begin
               // an underrun bit is flagged overhead so the far end throws it away
               nxt_st.ser_bit = pop & pop_bit;
               nxt_st.ohead   = !pop | pop_oh;
               nxt_st.frame   = pop_sof;
            end
         end
         E3RXPO_QUAD: begin
            nxt_st.ser_bit = 1'b0;
            nxt_st.ohead   = 1'b0;
            if (pop_sof) begin
               nxt_st.sof_pend = 1'b1;
               nxt_st.cnt      = '0;
               nxt_st.clk      = 1'b0;
            end
            if (pop && !pop_oh) begin
               // overhead bits stall the count, so only payload forms nibbles
               if (pop_sof || st_ff.cnt != QUAD_CNT_LOAD) begin
                  nxt_st.shreg = {st_ff.shreg[QUAD_WIDTH-3:0], pop_bit};
                  nxt_st.cnt   = pop_sof ? 2'h1 : st_ff.cnt + 2'h1;
                  if (!pop_sof && st_ff.cnt == QUAD_CNT_RISE) begin
                     nxt_st.clk = 1'b1;
                  end
               end else begin
                  // fourth payload bit: fall the clock and load the nibble together
                  nxt_st.clk      = 1'b0;
                  nxt_st.quad     = {st_ff.shreg, pop_bit};
                  nxt_st.frame    = st_ff.sof_pend;
                  nxt_st.sof_pend = 1'b0;
                  nxt_st.cnt      = '0;
               end
            end
         end
      endcase
   end

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         st_ff      <= '0;
         st_ff.mode <= MODE_RESET;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign o_rx_payload_serial_out    = st_ff.ser_bit;
   assign o_rx_payload_serial_out_oe = (st_ff.mode == E3RXPO_SERIAL);
   assign o_rx_payload_quad_out      = st_ff.quad;
   assign o_rx_payload_quad_out_oe   = (st_ff.mode == E3RXPO_QUAD);
   assign o_rx_payload_clock_out     = st_ff.clk;
   assign o_rx_overhead_bit_flag     = st_ff.ohead;
   assign o_rx_frame_start_pulse     = st_ff.frame;
endmodule

// [inc/e3rxpo_pkg.sv]
package e3rxpo_pkg;
   // serial rate of the payload clock, kHz
   localparam int unsigned E3_LINE_RATE_KHZ = 34368;
   localparam int unsigned CLOCK_RATE_KHZ   = 100000;
   // nibble clock pulses for every inbound frame
   localparam int unsigned QUAD_PULSES_PER_FRAME = 1060;
   localparam int unsigned QUAD_WIDTH            = 4;
   localparam int unsigned QUAD_CNT_WIDTH        = 2;
   // payload bit count at which the nibble clock rises / falls and the nibble loads
   localparam logic [1:0] QUAD_CNT_RISE = 2'h2;
   localparam logic [1:0] QUAD_CNT_LOAD = 2'h3;
   // fifo entry layout from the framer core
   localparam int unsigned FIFO_DEPTH    = 32;
   localparam int unsigned FIFO_WIDTH    = 3;
   localparam int unsigned FLD_DATA_POS  = 0;
   localparam int unsigned FLD_OHEAD_POS = 1;
   localparam int unsigned FLD_SOF_POS   = 2;
   typedef enum logic {
      E3RXPO_SERIAL,
      E3RXPO_QUAD
   } e3rxpo_mode_t;
   localparam e3rxpo_mode_t MODE_RESET = E3RXPO_SERIAL;
endpackage

// [verilog/e3rxpo_fifo.sv]
`timescale 1ns/1ps
module e3rxpo_fifo #(
   parameter int unsigned WIDTH = 3,
   parameter int unsigned DEPTH = 32
) (
   input  wire logic             i_clock,    // system clock
   input  wire logic             i_resetn,   // async reset, active low
   input  wire logic             i_wr_valid, // write side offers an entry
   output logic                  o_wr_ready, // room for an entry
   input  wire logic [WIDTH-1:0] i_wr_data,  // entry written
   output logic                  o_rd_valid, // an entry is waiting
   input  wire logic             i_rd_ready, // read side takes the entry
   output logic [WIDTH-1:0]      o_rd_data   // oldest entry
);
   localparam int unsigned AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0]                 wp;
      logic [AW:0]                 rp;
   } e3rxpo_fifo_state_t;
   e3rxpo_fifo_state_t st_ff;
   e3rxpo_fifo_state_t nxt_st;
   logic               full;
   logic               empty;
   assign empty      = (st_ff.wp == st_ff.rp);
   assign full       = (st_ff.wp[AW] != st_ff.rp[AW]) && (st_ff.wp[AW-1:0] == st_ff.rp[AW-1:0]);
   assign o_wr_ready = !full;
   assign o_rd_valid = !empty;
   assign o_rd_data  = st_ff.mem[st_ff.rp[AW-1:0]];
   always_comb begin
      nxt_st = st_ff;
      if (i_wr_valid && !full) begin
         nxt_st.mem[st_ff.wp[AW-1:0]] = i_wr_data;
         nxt_st.wp                    = st_ff.wp + 1'b1;
      end
      if (i_rd_ready && !empty) begin
         nxt_st.rp = st_ff.rp + 1'b1;
      end
   end
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
endmodule

// [test/e3rxpo_port_sva.sv]
`timescale 1ns/1ps
module e3rxpo_port_sva (
   input wire logic       i_clock,
   input wire logic       i_resetn,
   input wire logic       o_rx_payload_serial_out,
   input wire logic       o_rx_payload_serial_out_oe,
   input wire logic [3:0] o_rx_payload_quad_out,
   input wire logic       o_rx_payload_quad_out_oe,
   input wire logic       o_rx_payload_clock_out,
   input wire logic       o_rx_overhead_bit_flag,
   input wire logic       o_rx_frame_start_pulse
);
   wire ser = o_rx_payload_serial_out_oe;
   wire quad = o_rx_payload_quad_out_oe;
   wire clk = o_rx_payload_clock_out;
   wire frm = o_rx_frame_start_pulse;
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_resetn);
   one_mode_a: assert property (ser != quad) else $error("both or no payload pins driven");
   ser_idle_a: assert property (!ser |-> !o_rx_payload_serial_out) else $error("serial pin active");
   quad_idle_a: assert property (!quad |-> o_rx_payload_quad_out == 4'h0) else $error("quad pins active");
   ser_edge_a: assert property (ser && $stable(ser) && !$stable(o_rx_payload_serial_out) |-> $rose(clk))
      else $error("serial bit moved off rising clock");
   ser_run_a: assert property (ser && $rose(clk) |-> ##[1:3] (!clk || quad)) else $error("serial clock stuck");
   quad_edge_a: assert property (quad && $stable(quad) && !$stable(o_rx_payload_quad_out) |-> $fell(clk))
      else $error("nibble moved off falling clock");
   oh_low_a: assert property (quad |-> !o_rx_overhead_bit_flag) else $error("overhead flag in quad mode");
   sof_ser_a: assert property (ser && $rose(frm) |-> $rose(clk)) else $error("serial frame pulse misplaced");
   sof_quad_a: assert property (quad && $rose(frm) |-> $fell(clk)) else $error("quad frame pulse misplaced");
   quad_duty_a: assert property (quad && $rose(clk) |-> ##[1:4] (!clk) [*7]) else $error("nibble duty off");
   cover property (ser && $rose(frm));
   cover property (quad && $rose(frm));
   cover property (ser && o_rx_overhead_bit_flag);
endmodule
bind e3rxpo_port e3rxpo_port_sva u_sva (.*);

// [test/e3rxpo_term.sv]
`timescale 1ns/1ps
module e3rxpo_term (
   input wire logic       i_quad, // nibble mode strap
   input wire logic       i_clk,  // payload clock
   input wire logic       i_ser,  // serial bit
   input wire logic [3:0] i_nib,  // nibble
   input wire logic       i_oh,   // overhead flag
   input wire logic       i_sof   // frame start
);
   logic [31:0] shreg = '0;
   logic [3:0]  nib = '0;
   int          bits = 0, frames = 0, cnt = 0, gap = 0;
   always @(negedge i_clk) begin
      if (!i_quad) begin
         frames += i_sof;
         if (i_oh === 1'b0) begin
            shreg = {shreg[30:0], i_ser};
            bits++;
         end
      end
   end
   // gap counts nibble clocks from one frame pulse up to the next
   always @(posedge i_clk) begin
      if (i_quad) begin
         nib = i_nib;
         cnt++;
         if (i_sof) begin
            frames++;
            gap = cnt - 1;
            cnt = 1;
         end
      end
   end
endmodule

// [test/e3rxpo_port_test.sv]
`timescale 1ns/1ps
module e3rxpo_port_test;
   import e3rxpo_pkg::*;
   logic       clk = 0, rstn = 0, line = 0, strap = 0, valid = 0, cbit = 0, coh = 0, csof = 0, full_seen = 0;
   logic       ready, ser, ser_oe, nib_oe, pclk, ohf, frm;
   logic [3:0] nib;
   int         n_fail = 0, tests_run = 0;
   always #5 clk = ~clk;
   always #14.55 line = ~line;
   e3rxpo_port u_dut (.i_clock(clk), .i_resetn(rstn), .i_recovered_line_clock(line), .i_quad_mode_select_strap(strap),
      .i_core_valid(valid), .o_core_ready(ready), .i_core_bit(cbit), .i_core_overhead(coh), .i_core_sof(csof),
      .o_rx_payload_serial_out(ser), .o_rx_payload_serial_out_oe(ser_oe), .o_rx_payload_quad_out(nib),
      .o_rx_payload_quad_out_oe(nib_oe), .o_rx_payload_clock_out(pclk), .o_rx_overhead_bit_flag(ohf),
      .o_rx_frame_start_pulse(frm));
   e3rxpo_term u_term (.i_quad(strap), .i_clk(pclk), .i_ser(ser), .i_nib(nib), .i_oh(ohf), .i_sof(frm));
   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      tests_run++;
      if (got !== want) begin
         n_fail++;
         $display("mismatch t=%0t got %h exp %h", $time, got, want);
      end
   endtask
   // held until the edge that finds room; a full fifo is noted
   task automatic send_bit(input logic b, input logic o, input logic s);
      valid = 1;
      cbit = b;
      coh = o;
      csof = s;
      while (ready !== 1'b1) begin
         full_seen = 1;
         @(posedge clk) #1;
      end
      @(posedge clk) #1;
   endtask
   task automatic send_frame(input int npay);
      for (int i = 0; i < 8; i++) send_bit(i[0], 1'b1, i == 0);
      for (int j = 0; j < npay; j++) send_bit(j[1] ^ j[3], 1'b0, 1'b0);
      valid = 0;
   endtask
   task automatic t_serial;
      logic [31:0] want;
      int          b0, f0;
      for (int j = 0; j < 32; j++) want[31-j] = j[1] ^ j[3];
      b0 = u_term.bits;
      f0 = u_term.frames;
      send_frame(32);
      send_frame(32);
      for (int k = 0; k < 3000 && u_term.bits < b0 + 64; k++) @(posedge clk) #1;
      chk(u_term.bits - b0, 64);
      chk(u_term.shreg, want);
      chk(u_term.frames - f0, 2);
      chk(full_seen, 1'b1);
      $display("test serial done");
   endtask
   task automatic t_quad;
      int f0;
      strap = 1;
      // let the strap clear its synchroniser before the first frame start pops
      repeat (4) @(posedge clk) #1;
      f0 = u_term.frames;
      send_frame(4 * QUAD_PULSES_PER_FRAME);
      send_frame(4 * QUAD_PULSES_PER_FRAME);
      send_frame(8);
      for (int k = 0; k < 3000 && u_term.frames < f0 + 3; k++) @(posedge clk) #1;
      chk(u_term.gap, QUAD_PULSES_PER_FRAME);
      chk(u_term.nib, 4'h3);
      chk({ser_oe, nib_oe, ohf}, 3'h2);
      $display("test quad done");
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clk);
      n_fail++;
      print_verdict();
   end
   initial begin
      repeat (6) @(posedge clk);
      #1 rstn = 1;
      chk({ser_oe, nib_oe, ready, pclk, frm, ohf}, 6'h28);
      t_serial();
      t_quad();
      print_verdict();
   end
endmodule
